// [src/chan_cfg_pkg.sv]
/*
 * Shared constants for the channel configuration register bank: register
 * indices, field positions, reset values, power modes and the input codes.
 * Assumes a 32-bit APB slave on one 100 MHz clock.
 */
package chan_cfg_pkg;

    // Channel and data widths.
    localparam int NUM_CHANNELS = 16;
    localparam int CHAN_W       = 4;
    localparam int SAMPLE_W     = 16;
    localparam int CODE_W       = 5;
    localparam int SETUP_W      = 3;
    localparam int NUM_SOURCES  = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CHANNEL_FIRST = 8'h09;
    localparam logic [7:0] IDX_CHANNEL_LAST  = 8'h18;
    localparam logic [7:0] IDX_CONTROL       = 8'h20;
    localparam logic [7:0] IDX_STATUS        = 8'h21;
    localparam logic [7:0] IDX_MASK          = 8'h22;
    localparam logic [7:0] IDX_LIMITS        = 8'h23;

    // Field positions inside a channel register.
    localparam int SETUP_HI   = 22;
    localparam int SETUP_LO   = 20;
    localparam int SWITCH_BIT = 19;
    localparam int MONITOR_BIT = 18;
    localparam int INPUT_HI   = 17;
    localparam int INPUT_LO   = 13;

    // Field positions inside the control register.
    localparam int CTRL_MODE_LO   = 0;
    localparam int CTRL_MODE_HI   = 1;
    localparam int CTRL_STBY_BIT  = 2;
    localparam int CTRL_FIFO_BIT  = 3;

    // Field positions inside the limits register.
    localparam int LIM_LOW_LO  = 0;
    localparam int LIM_HIGH_LO = 16;

    // Status and mask bit positions.
    localparam int EVT_W     = 2;
    localparam int EVT_BELOW = 0;
    localparam int EVT_ABOVE = 1;

    // Reset values.
    localparam logic [2:0]          RST_SETUP  = 3'h0;
    localparam logic                RST_SWITCH = 1'b0;
    localparam logic                RST_MON    = 1'b0;
    localparam logic [CODE_W-1:0]   RST_INPUT  = 5'h00;
    localparam logic [SAMPLE_W-1:0] RST_LOW    = 16'h0000;
    localparam logic [SAMPLE_W-1:0] RST_HIGH   = 16'hFFFF;

    // Positive-input codes that connect a source; every other code is reserved.
    localparam logic [NUM_SOURCES-1:0] VALID_INPUT_CODES = 32'h3FFFCC33;
    localparam logic [CODE_W-1:0] CODE_INPUT1     = 5'h01;
    localparam logic [CODE_W-1:0] CODE_INPUT4     = 5'h0A;
    localparam logic [CODE_W-1:0] CODE_INPUT7     = 5'h0F;
    localparam logic [CODE_W-1:0] CODE_TEMP       = 5'h10;
    localparam logic [CODE_W-1:0] CODE_NEG_SUPPLY = 5'h11;
    localparam logic [CODE_W-1:0] CODE_DREG_NEG   = 5'h1B;

    // Device power modes.
    typedef enum logic [1:0] {
        MODE_ACTIVE     = 2'b00,
        MODE_STANDBY    = 2'b01,
        MODE_POWER_DOWN = 2'b10,
        MODE_SPARE      = 2'b11
    } power_mode_t;

endpackage

// [src/input_source_decode.sv]
/*
 * Decodes a positive-input code into a one-hot source select.
 * Assumes the code comes from a register on the same clock.
 */
`timescale 1ns/1ps
module input_source_decode
    import chan_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    // Code in.
    input  wire logic                   converting,
    input  wire logic [CODE_W-1:0]      code,
    // Select out.
    output logic      [NUM_SOURCES-1:0] source_select
);

    // One-hot select of the coded source; reserved codes select nothing.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            source_select <= '0;
        end else if (converting) begin
            source_select <= VALID_INPUT_CODES & (32'h00000001 << code);
        end else begin
            source_select <= '0;
        end
    end

endmodule // input_source_decode

// [src/threshold_check.sv]
/*
 * Compares each monitored sample with the lower and upper limits.
 * Assumes samples arrive as one-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
module threshold_check
    import chan_cfg_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Sample in.
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample_data,
    input  wire logic             monitor_on,
    // Limits.
    input  wire logic [WIDTH-1:0] lower_limit_value,
    input  wire logic [WIDTH-1:0] upper_limit_value,
    // Crossing pulses.
    output logic                  below_pulse,
    output logic                  above_pulse
);

    // A monitored sample outside the limits gives a one-cycle pulse.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            below_pulse <= 1'b0;
            above_pulse <= 1'b0;
        end else begin
            below_pulse <= sample_valid && monitor_on && (sample_data < lower_limit_value);
            above_pulse <= sample_valid && monitor_on && (sample_data > upper_limit_value);
        end
    end

endmodule // threshold_check

// [src/channel_config_fields.sv]
/*
 * Per-channel configuration register bank behind an APB slave: setup
 * select, low-side switch enable, threshold monitor enable and positive
 * input select for each channel, plus control, status, mask and limits.
 * Word indices: channels 0x09 to 0x18,
 * control 0x20, status 0x21, mask 0x22
 * and limits 0x23; others get pslverr.
 * Control: bits 1:0 mode, bit 2 standby
 * switch enable, bit 3 FIFO enable.
 * Status and mask: bit 0 below, bit 1
 * above the limits.
 * Limits: lower in 15:0, upper in 31:16.
 * Unused bits read as zero.
 * All fields reset to zero, the upper
 * limit to all ones.
 * Assumes the sequencer supplies the active channel, a converting level
 * and sample strobes on the same clock, and the APB master is on sys_clk.
 */

`timescale 1ns/1ps
module channel_config_fields
    import chan_cfg_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    // Clock and reset.
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,

    // APB slave.
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,

    // Sequencer side.
    input  wire logic [CHAN_W-1:0]      active_channel,
    input  wire logic                   converting,
    input  wire logic                   sample_valid,
    input  wire logic [SAMPLE_W-1:0]    sample_data,

    // Steering outputs.
    output logic      [SETUP_W-1:0]     setup_select,
    output logic      [NUM_SOURCES-1:0] source_select,
    output logic                        low_side_switch_pin,
    output logic                        low_side_switch_pin_oe,

    // Interrupt.
    output logic                        irq
);

    // Register word index of an APB byte address.
    // Every register is a whole word.
    function automatic logic [7:0] word_index(input logic [11:0] addr);
        return addr[9:2];
    endfunction

    // True when an index falls inside the channel register range.
    // Shared by the write path and read mux.
    function automatic logic is_channel(input logic [7:0] idx);
        return (idx >= IDX_CHANNEL_FIRST) && (idx <= IDX_CHANNEL_LAST);
    endfunction

    // Channel number of an index inside the channel range.
    // Valid only where is_channel holds.
    function automatic logic [CHAN_W-1:0] channel_of(input logic [7:0] idx);
        logic [7:0] diff;
        diff = idx - IDX_CHANNEL_FIRST;
        return diff[CHAN_W-1:0];
    endfunction

    // Per-channel fields.
    // One entry per channel number.
    logic [SETUP_W-1:0]  setup_sel     [CHANNELS];
    logic                low_side_switch_enable [CHANNELS];
    logic                threshold_monitor_enable [CHANNELS];
    logic [CODE_W-1:0]   positive_input_select [CHANNELS];

    // Control, status, mask and limits.
    // Software state beyond the channels.
    power_mode_t         power_mode;
    logic                standby_switch_enable;
    logic                fifo_enable;
    logic [EVT_W-1:0]    status;
    logic [EVT_W-1:0]    mask;
    logic [SAMPLE_W-1:0] lower_limit_value;
    logic [SAMPLE_W-1:0] upper_limit_value;

    // Bus decode.
    // Combinational, from the live bus.
    logic [7:0]          idx;
    logic                access;
    logic                wr_en;
    logic                mapped;
    logic [CHAN_W-1:0]   wr_chan;

    // Event pulses and steering terms.
    // Each pulse lasts one cycle.
    logic                below_pulse;
    logic                above_pulse;
    logic [EVT_W-1:0]    events;
    logic                next_switch;
    logic                monitor_on;
    logic [31:0]         next_prdata;

    // Decode of the current APB access phase.
    // The top two address bits are ignored.
    // Writes to unmapped indices are dropped.
    assign idx     = word_index(paddr);
    assign access  = psel && penable;
    assign wr_en   = access && pwrite && mapped;
    assign wr_chan = channel_of(idx);

    // Which indices answer without an error.
    // Others take pslverr and read zero.
    always_comb begin
        mapped = is_channel(idx) ||
                 (idx == IDX_CONTROL) ||
                 (idx == IDX_STATUS) ||
                 (idx == IDX_MASK) ||
                 (idx == IDX_LIMITS);
    end

    // Zero-wait slave: every access completes in its first access cycle.
    // Reads need no wait: prdata loads in setup.
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Channel field storage; reserved input codes are kept as written.
    // One write sets all fields of a channel.
    // Bits 31:23 and bits 12:0 are not kept.
    // Other indices leave the channels alone.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < CHANNELS; i++) begin
                setup_sel[i]                <= RST_SETUP;
                low_side_switch_enable[i]   <= RST_SWITCH;
                threshold_monitor_enable[i] <= RST_MON;
                positive_input_select[i]    <= RST_INPUT;
            end
        end else if (wr_en && is_channel(idx)) begin
            setup_sel[wr_chan]                <= pwdata[SETUP_HI:SETUP_LO];
            low_side_switch_enable[wr_chan]   <= pwdata[SWITCH_BIT];
            threshold_monitor_enable[wr_chan] <= pwdata[MONITOR_BIT];
            positive_input_select[wr_chan]    <= pwdata[INPUT_HI:INPUT_LO];
        end
    end

    // Control register: power mode, standby switch enable, FIFO enable.
    // All three fields are written together.
    // Mode 3 is spare; the switch stays open.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode            <= MODE_ACTIVE;
            standby_switch_enable <= 1'b0;
            fifo_enable           <= 1'b0;
        end else if (wr_en && (idx == IDX_CONTROL)) begin
            power_mode            <= power_mode_t'(pwdata[CTRL_MODE_HI:CTRL_MODE_LO]);
            standby_switch_enable <= pwdata[CTRL_STBY_BIT];
            fifo_enable           <= pwdata[CTRL_FIFO_BIT];
        end
    end

    // Limits register holding the lower and upper sample bounds.
    // They reset wide open, so nothing is
    // flagged until software narrows them.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lower_limit_value <= RST_LOW;
            upper_limit_value <= RST_HIGH;
        end else if (wr_en && (idx == IDX_LIMITS)) begin
            lower_limit_value <= pwdata[LIM_LOW_LO +: SAMPLE_W];
            upper_limit_value <= pwdata[LIM_HIGH_LO +: SAMPLE_W];
        end
    end

    // Interrupt mask register.
    // A set bit lets that status bit raise irq.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask <= '0;
        end else if (wr_en && (idx == IDX_MASK)) begin
            mask <= pwdata[EVT_W-1:0];
        end
    end

    // Sticky status: a write of one clears, a same-cycle event wins.
    // A clear touches only bits written as
    // one, and an event in the same cycle
    // keeps its bit, so no crossing is lost.
    assign events[EVT_BELOW] = below_pulse;
    assign events[EVT_ABOVE] = above_pulse;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else if (wr_en && (idx == IDX_STATUS)) begin
            status <= (status & ~pwdata[EVT_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    // Level interrupt while any unmasked status bit is set.
    // It rises a cycle after the status bit;
    // masked bits stay readable in status.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // Read data mux; unused bits read as zero.
    // Channel fields read back as written,
    // reserved input codes included.
    always_comb begin
        next_prdata = 32'h00000000;
        if (is_channel(idx)) begin
            next_prdata[SETUP_HI:SETUP_LO] = setup_sel[wr_chan];
            next_prdata[SWITCH_BIT]        = low_side_switch_enable[wr_chan];
            next_prdata[MONITOR_BIT]       = threshold_monitor_enable[wr_chan];
            next_prdata[INPUT_HI:INPUT_LO] = positive_input_select[wr_chan];
        end else if (idx == IDX_CONTROL) begin
            next_prdata[CTRL_MODE_HI:CTRL_MODE_LO] = power_mode;
            next_prdata[CTRL_STBY_BIT]             = standby_switch_enable;
            next_prdata[CTRL_FIFO_BIT]             = fifo_enable;
        end else if (idx == IDX_STATUS) begin
            next_prdata[EVT_W-1:0] = status;
        end else if (idx == IDX_MASK) begin
            next_prdata[EVT_W-1:0] = mask;
        end else if (idx == IDX_LIMITS) begin
            next_prdata[LIM_LOW_LO +: SAMPLE_W]  = lower_limit_value;
            next_prdata[LIM_HIGH_LO +: SAMPLE_W] = upper_limit_value;
        end
    end

    // Read data comes from flip-flops, loaded during the setup cycle.
    // This keeps the access phase free of
    // wait states; writes leave it alone.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Setup group in use by the active channel, including groups 6 and 7.
    // The code passes through unchanged; the
    // sequencer picks its setup group by it.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_select <= RST_SETUP;
        end else begin
            setup_select <= setup_sel[active_channel];
        end
    end

    // Low-side switch gating by channel bit, conversion and power mode.
    // Power-down always wins. Standby needs
    // no conversion, so a bridge may stay
    // powered between bursts if enabled.
    // The default catches the spare mode.
    always_comb begin
        unique case (power_mode)
            MODE_POWER_DOWN: next_switch = 1'b0;
            MODE_STANDBY:    next_switch = standby_switch_enable &&
                                           low_side_switch_enable[active_channel];
            MODE_ACTIVE:     next_switch = converting &&
                                           low_side_switch_enable[active_channel];
            default:         next_switch = 1'b0;
        endcase
    end

    // The switch pin only sinks to the negative supply; it never drives high.
    // The enable is registered so it cannot
    // glitch while mode or channel moves.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_side_switch_pin_oe <= 1'b0;
        end else begin
            low_side_switch_pin_oe <= next_switch;
        end
    end

    // The pin value itself never changes.
    assign low_side_switch_pin = 1'b0;

    // Monitoring is live only with the FIFO enabled.
    // The active channel's enable gates it too.
    assign monitor_on = fifo_enable && threshold_monitor_enable[active_channel];

    // Limit comparison of each sample.
    // Unsigned and strict: a sample equal
    // to a limit is not a crossing.
    threshold_check #(
        .WIDTH (SAMPLE_W)
    ) u_threshold (
        .sys_clk           (sys_clk),
        .rst_b             (rst_b),
        .sample_valid      (sample_valid),
        .sample_data       (sample_data),
        .monitor_on        (monitor_on),
        .lower_limit_value (lower_limit_value),
        .upper_limit_value (upper_limit_value),
        .below_pulse       (below_pulse),
        .above_pulse       (above_pulse)
    );

    // Positive input source selection for the active channel.
    // Reserved codes and idle cycles
    // select nothing.
    input_source_decode u_source (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .converting    (converting),
        .code          (positive_input_select[active_channel]),
        .source_select (source_select)
    );

endmodule // channel_config_fields

// [verif/channel_config_fields_properties.sv]
/*
 * Port-level checker for the channel configuration register bank.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module channel_config_fields_properties
    import chan_cfg_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
) (
    // Clock and reset.
    input wire logic                   sys_clk,
    input wire logic                   rst_b,
    // APB slave.
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Sequencer side.
    input wire logic [CHAN_W-1:0]      active_channel,
    input wire logic                   converting,
    input wire logic                   sample_valid,
    input wire logic [SAMPLE_W-1:0]    sample_data,
    // Steering outputs.
    input wire logic [SETUP_W-1:0]     setup_select,
    input wire logic [NUM_SOURCES-1:0] source_select,
    input wire logic                   low_side_switch_pin,
    input wire logic                   low_side_switch_pin_oe,
    input wire logic                   irq
);
    logic [3:0]  ctrl;
    logic [22:13] chan [CHANNELS];
    logic [7:0]  widx;
    logic [7:0]  woff;
    logic [22:13] cur;
    logic        take;
    logic        mapped;

    // Decodes the word index of the current transfer.
    assign widx   = paddr[9:2];
    assign woff   = widx - IDX_CHANNEL_FIRST;
    assign take   = psel && penable && pwrite && pready;
    assign mapped = (widx >= IDX_CHANNEL_FIRST && widx <= IDX_CHANNEL_LAST) || (widx >= IDX_CONTROL && widx <= IDX_LIMITS);
    assign cur    = chan[active_channel];

    // Shadows the control register so the switch gating can be predicted.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) ctrl <= 4'h0;
        else if (take && widx == IDX_CONTROL) ctrl <= pwdata[3:0];
    end

    // Shadows the channel fields written by software.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < CHANNELS; i++) chan[i] <= 10'h000;
        end else if (take && widx >= IDX_CHANNEL_FIRST && widx <= IDX_CHANNEL_LAST) begin
            chan[woff[CHAN_W-1:0]] <= pwdata[22:13];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_switch_armed;
        cur[19] && ((ctrl[1:0] == MODE_ACTIVE && converting) || (ctrl[1:0] == MODE_STANDBY && ctrl[2]));
    endsequence

    a_unmapped_error: assert property (s_access ##0 (!mapped && !pwrite) |-> pslverr && prdata == 32'h0)
        else $error("Unmapped read was not refused.");
    a_mapped_clean: assert property (s_access ##0 mapped |-> !pslverr)
        else $error("Mapped access flagged as error.");
    a_switch_closes: assert property (s_switch_armed |=> low_side_switch_pin_oe)
        else $error("Switch stayed open while armed.");
    a_idle_opens: assert property (ctrl[1:0] == MODE_ACTIVE && !converting |=> !low_side_switch_pin_oe)
        else $error("Switch closed outside a conversion.");
    a_pdown_opens: assert property (ctrl[1:0] == MODE_POWER_DOWN |=> !low_side_switch_pin_oe)
        else $error("Switch closed in power-down.");
    a_standby_gated: assert property (ctrl[1:0] == MODE_STANDBY && !ctrl[2] |=> !low_side_switch_pin_oe)
        else $error("Switch closed in standby without enable.");
    a_bit_off: assert property (!cur[19] |=> !low_side_switch_pin_oe)
        else $error("Switch closed with channel bit clear.");
    a_pin_sinks: assert property (low_side_switch_pin_oe |-> low_side_switch_pin == 1'b0)
        else $error("Switch pin driven high.");
    a_setup_follows: assert property (1'b1 |=> setup_select == $past(cur[22:20]))
        else $error("Setup select does not follow the channel.");
    a_source_onehot: assert property (converting && VALID_INPUT_CODES[cur[17:13]] |=>
        source_select == (32'h1 << $past(cur[17:13])))
        else $error("Source select is not the decoded code.");
    a_reserved_none: assert property (!converting || !VALID_INPUT_CODES[cur[17:13]] |=> source_select == 32'h0)
        else $error("Source connected for a reserved code.");
endmodule // channel_config_fields_properties

// [verif/testbench.sv]
/*
 * Self-checking bench for the channel configuration register bank.
 * Assumes zero-wait APB answers are awaited, never counted on.
 */
`timescale 1ns/1ps
module testbench
    import chan_cfg_pkg::*;
;
    logic                   sys_clk, rst_b, psel, penable, pwrite, converting, sample_valid;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic                   pready, pslverr, oe, pin, irq, err;
    logic [CHAN_W-1:0]      active_channel;
    logic [SAMPLE_W-1:0]    sample_data;
    logic [SETUP_W-1:0]     setup_select;
    logic [NUM_SOURCES-1:0] source_select;
    logic [4:0]             codes [11] = '{5'h01, 5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h1B, 5'h09, 5'h0C, 5'h0D};
    int                     errors, comparisons;
    localparam logic [7:0]  CH2 = IDX_CHANNEL_FIRST + 8'h02;

    channel_config_fields dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .active_channel(active_channel), .converting(converting), .sample_valid(sample_valid),
        .sample_data(sample_data), .setup_select(setup_select), .source_select(source_select),
        .low_side_switch_pin(pin), .low_side_switch_pin_oe(oe), .irq(irq));

    // Free-running 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic sw_case(input logic [31:0] c, input logic cv, input logic b, input logic exp);
        apb(1'b1, IDX_CONTROL, c);
        converting <= cv;
        apb(1'b1, CH2, {12'h000, b, 19'h00000});
        settle(2);
        check({31'h0, oe}, {31'h0, exp});
        check({31'h0, pin}, 32'h0);
    endtask

    task automatic sample_case(input logic [15:0] d, input logic [31:0] st, input logic ir);
        @(posedge sys_clk);
        sample_valid <= 1'b1; sample_data <= d;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        settle(3);
        check({31'h0, irq}, {31'h0, ir});
        apb(1'b0, IDX_STATUS, 32'h0);
        check(rd, st);
        apb(1'b1, IDX_STATUS, 32'h3);
        settle(2);
        check({31'h0, irq}, 32'h0);
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end

    // Main test sequence.
    initial begin
        sys_clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        converting = 0; sample_valid = 0; sample_data = 0; active_channel = 0; errors = 0; comparisons = 0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(1'b0, IDX_CHANNEL_FIRST, 32'h0); check(rd, 32'h0);
        apb(1'b0, IDX_CHANNEL_LAST, 32'h0); check(rd, 32'h0);
        apb(1'b1, IDX_CHANNEL_FIRST + 8'h03, 32'hFFFFFFFF);
        apb(1'b0, IDX_CHANNEL_FIRST + 8'h03, 32'h0); check(rd, 32'h007FE000);
        apb(1'b1, IDX_CHANNEL_FIRST + 8'h04, 32'h007F6000);
        apb(1'b0, IDX_CHANNEL_FIRST + 8'h04, 32'h0); check(rd, 32'h007F6000);
        active_channel <= 4'h2;
        converting <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, CH2, 32'(s) << 20);
            settle(2);
            check({29'h0, setup_select}, 32'(s));
        end
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, CH2, {14'h0, codes[i], 13'h0});
            settle(2);
            check(source_select, (i < 8) ? (32'h1 << codes[i]) : 32'h0);
            apb(1'b0, CH2, 32'h0); check(rd, {14'h0, codes[i], 13'h0});
        end
        sw_case(32'h0, 1'b1, 1'b1, 1'b1);
        sw_case(32'h0, 1'b0, 1'b1, 1'b0);
        sw_case(32'h0, 1'b1, 1'b0, 1'b0);
        sw_case(32'h2, 1'b1, 1'b1, 1'b0);
        sw_case(32'h6, 1'b1, 1'b1, 1'b0);
        sw_case(32'h1, 1'b1, 1'b1, 1'b0);
        sw_case(32'h5, 1'b1, 1'b1, 1'b1);
        sw_case(32'h3, 1'b1, 1'b1, 1'b0);
        apb(1'b1, IDX_LIMITS, 32'hF0001000);
        apb(1'b1, IDX_MASK, 32'h3);
        apb(1'b1, IDX_CONTROL, 32'h8);
        apb(1'b1, CH2, 32'h00040000);
        sample_case(16'h0800, 32'h1, 1'b1);
        sample_case(16'hF001, 32'h2, 1'b1);
        sample_case(16'h1000, 32'h0, 1'b0);
        apb(1'b1, IDX_MASK, 32'h0);
        sample_case(16'h0800, 32'h1, 1'b0);
        apb(1'b1, IDX_MASK, 32'h3);
        apb(1'b1, IDX_CONTROL, 32'h0);
        sample_case(16'h0800, 32'h0, 1'b0);
        apb(1'b1, IDX_CONTROL, 32'h8);
        apb(1'b1, CH2, 32'h0);
        sample_case(16'h0800, 32'h0, 1'b0);
        apb(1'b0, 8'h30, 32'h0); check(rd, 32'h0); check({31'h0, err}, 32'h1);
        give_verdict();
    end
endmodule // testbench

bind channel_config_fields channel_config_fields_properties #(.CHANNELS(CHANNELS)) u_props (.sys_clk(sys_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .active_channel(active_channel), .converting(converting),
    .sample_valid(sample_valid), .sample_data(sample_data), .setup_select(setup_select),
    .source_select(source_select), .low_side_switch_pin(low_side_switch_pin),
    .low_side_switch_pin_oe(low_side_switch_pin_oe), .irq(irq));
